// ### core/aps_cfg.svh
// Constants of the address pin and switch sensing block
// Summary of operation
// - High-side and low-side probes alternate and are never active together.
// - Each probe pulses once every 1024 us; comparator evaluated at each pulse.
// - Comparator output is debounced for 64 us before updating pin state.
// - Low-side probe: one sets high; zero moves high to floating.
// - High-side probe: one sets low; zero moves low to floating.
// - High reports address bit 1, low reports 0, floating reported separately.
// - High to floating starts secure-position move only after 64 ms debounce.
// - Switch input gives closed flag 0 when open, 1 when closed.
// - Switch flag changes only in step with a probe pulse.
// - After each probe pulse switch flag and position are captured together.
// - Readback frame: flag plus address, position high, low, status, checksum.
// - Node address is four programmed bits above three hardwired bits.
`ifndef APS_CFG_SVH
`define APS_CFG_SVH
`define APS_CLK_MHZ 100
`define APS_PERIOD_US 1024
`define APS_PULSE_US 64
`define APS_LOST_MS 64
`define APS_HALF_CYC (`APS_PERIOD_US * `APS_CLK_MHZ / 2)
`define APS_PULSE_CYC (`APS_PULSE_US * `APS_CLK_MHZ)
// Cycles lost to probe register, synchroniser and edge detect before the count can start
`define APS_SETTLE_CYC 8
`define APS_LOST_CYC (`APS_LOST_MS * 1000 * `APS_CLK_MHZ)
`define APS_FRAME_BYTES 5
`define APS_OFF_CTRL 12'h000
`define APS_OFF_STAT 12'h004
`define APS_OFF_POS 12'h008
`define APS_OFF_FRAME0 12'h00C
`define APS_OFF_FRAME1 12'h010
`define APS_OFF_IRQ 12'h014
`define APS_OFF_MASK 12'h018
`define APS_IRQ_W 3
`endif

// ### core/aps_pkg.sv
// Types of the address pin and switch sensing block
package aps_pkg;
   typedef enum logic [1:0]
   {
      APS_FLOAT = 2'b00,
      APS_LOW = 2'b01,
      APS_HIGH = 2'b10
   } aps_pin_t;
endpackage

// ### core/aps_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/10ps
`include "aps_cfg.svh"
module aps_sync
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic async_in,
   output logic sync_out
);
   logic [2:0] stage_reg;
   // First stage feeds only the second
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stage_reg <= 3'b000;
      else
         stage_reg <= {stage_reg[1:0], async_in};
   end
   // Accept a change only when stages two and three agree
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_out <= 1'b0;
      else if (stage_reg[1] == stage_reg[2])
         sync_out <= stage_reg[2];
   end
endmodule

// ### core/aps_sense.sv
// Address pin and switch sensing with APB register access
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "aps_cfg.svh"
module aps_sense
#(
   parameter int LOST_CYC = `APS_LOST_CYC,
   parameter int HALF_CYC = `APS_HALF_CYC,
   parameter int PULSE_CYC = `APS_PULSE_CYC
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sense_comparator_out,
   input wire logic switch_comparator_out,
   input wire logic [15:0] actual_position,
   input wire logic [7:0] status_flags,
   output logic high_side_probe,
   output logic low_side_probe,
   output logic [1:0] address_state,
   output logic secure_position_req,
   output logic switch_closed_flag,
   output logic irq
);
   logic cmp_sync;
   logic sw_sync;
   logic [31:0] phase_cnt_reg;
   logic [31:0] db_cnt_reg;
   logic [31:0] lost_cnt_reg;
   logic side_reg;
   logic probing_reg;
   logic cmp_ok;
   logic cmp_prev_reg;
   logic eval_pulse;
   logic lost_pending_reg;
   logic [3:0] programmed_address_bits_reg;
   logic [1:0] hw_fixed_reg;
   logic [15:0] pos_latched_reg;
   aps_pkg::aps_pin_t pin_reg;
   aps_pkg::aps_pin_t pin_next;
   logic [2:0] hardwired_address_bits;
   logic [6:0] node_address;
   logic [7:0] checksum;
   logic [`APS_IRQ_W-1:0] irq_stat_reg;
   logic [`APS_IRQ_W-1:0] irq_mask_reg;
   logic [`APS_IRQ_W-1:0] irq_event;
   logic apb_wr;
   logic apb_rd;

   aps_sync u_cmp_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(sense_comparator_out),
      .sync_out(cmp_sync)
   );

   aps_sync u_sw_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(switch_comparator_out),
      .sync_out(sw_sync)
   );

   // Zero-wait-state APB slave; every access completes in its access cycle
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;

   // Probe timing: one pulse each half period, sides alternate so each repeats every period
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_cnt_reg <= 32'h0000_0000;
         side_reg <= 1'b0;
         probing_reg <= 1'b0;
      end
      else if (phase_cnt_reg == 32'(HALF_CYC - 1))
      begin
         phase_cnt_reg <= 32'h0000_0000;
         side_reg <= ~side_reg;
         probing_reg <= 1'b1;
      end
      else
      begin
         phase_cnt_reg <= phase_cnt_reg + 32'h0000_0001;
         if (phase_cnt_reg == 32'(PULSE_CYC - 1))
            probing_reg <= 1'b0;
      end
   end

   // Probe outputs are decoded from one side bit so both can never be high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         high_side_probe <= 1'b0;
         low_side_probe <= 1'b0;
      end
      else
      begin
         high_side_probe <= probing_reg && side_reg;
         low_side_probe <= probing_reg && !side_reg;
      end
   end

   // Comparator must hold one value for the pulse after the settle margin to count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         db_cnt_reg <= 32'h0000_0000;
         cmp_prev_reg <= 1'b0;
      end
      else
      begin
         cmp_prev_reg <= cmp_sync;
         if (!probing_reg || cmp_sync != cmp_prev_reg)
            db_cnt_reg <= 32'h0000_0000;
         else
            db_cnt_reg <= db_cnt_reg + 32'h0000_0001;
      end
   end

   // Debounced result; the settle margin covers the sync latency, so the rest of the pulse must be stable
   assign cmp_ok = (db_cnt_reg >= 32'(PULSE_CYC - `APS_SETTLE_CYC)) && cmp_sync;

   // Evaluation at the end of each probe pulse
   assign eval_pulse = probing_reg && (phase_cnt_reg == 32'(PULSE_CYC - 1));

   // Transition table of the address pin
   always_comb
   begin
      pin_next = pin_reg;
      if (!side_reg)
      begin
         if (cmp_ok)
            pin_next = aps_pkg::APS_HIGH;
         else if (pin_reg == aps_pkg::APS_HIGH)
            pin_next = aps_pkg::APS_FLOAT;
      end
      else
      begin
         if (cmp_ok)
            pin_next = aps_pkg::APS_LOW;
         else if (pin_reg == aps_pkg::APS_LOW)
            pin_next = aps_pkg::APS_FLOAT;
      end
   end

   // Address pin state and reported result
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_reg <= aps_pkg::APS_FLOAT;
         address_state <= 2'b00;
      end
      else
      begin
         if (eval_pulse)
            pin_reg <= pin_next;
         address_state <= pin_reg;
      end
   end

   // Lost pin debounce; a short dropout never reaches the motion logic
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lost_cnt_reg <= 32'h0000_0000;
         lost_pending_reg <= 1'b0;
         secure_position_req <= 1'b0;
      end
      else if (eval_pulse && pin_reg == aps_pkg::APS_HIGH && pin_next == aps_pkg::APS_FLOAT)
      begin
         lost_pending_reg <= 1'b1;
         lost_cnt_reg <= 32'h0000_0000;
         secure_position_req <= 1'b0;
      end
      else if (lost_pending_reg && pin_reg != aps_pkg::APS_FLOAT)
      begin
         lost_pending_reg <= 1'b0;
         lost_cnt_reg <= 32'h0000_0000;
      end
      else if (lost_pending_reg)
      begin
         if (lost_cnt_reg == 32'(LOST_CYC - 1))
         begin
            lost_pending_reg <= 1'b0;
            secure_position_req <= 1'b1;
         end
         else
            lost_cnt_reg <= lost_cnt_reg + 32'h0000_0001;
      end
      else if (pin_reg != aps_pkg::APS_FLOAT)
         secure_position_req <= 1'b0;
   end

   // Switch flag and position captured as a pair at each pulse end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         switch_closed_flag <= 1'b0;
         pos_latched_reg <= 16'h0000;
      end
      else if (eval_pulse)
      begin
         switch_closed_flag <= sw_sync;
         pos_latched_reg <= actual_position;
      end
   end

   // Programmed address bits, software owned
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         programmed_address_bits_reg <= 4'h0;
         hw_fixed_reg <= 2'b00;
      end
      else if (apb_wr && paddr == `APS_OFF_CTRL)
      begin
         programmed_address_bits_reg <= pwdata[6:3];
         hw_fixed_reg <= pwdata[1:0];
      end
   end

   // Node address: sensed bit in the top hardwired position
   assign hardwired_address_bits = {pin_reg == aps_pkg::APS_HIGH, hw_fixed_reg};
   assign node_address = {programmed_address_bits_reg, hardwired_address_bits};
   // Inverted modulo-256 sum with carry wrap over the four data bytes
   always_comb
   begin
      logic [9:0] sum;
      sum = 10'({2'b00, switch_closed_flag, node_address}) + 10'(pos_latched_reg[15:8])
         + 10'(pos_latched_reg[7:0]) + 10'(status_flags);
      sum = 10'(sum[7:0]) + 10'(sum[9:8]);
      checksum = ~(sum[7:0] + {6'b00_0000, sum[9:8]});
   end

   // Sticky events: pin lost, secure request, switch change
   assign irq_event[0] = eval_pulse && pin_reg == aps_pkg::APS_HIGH && pin_next == aps_pkg::APS_FLOAT;
   assign irq_event[1] = lost_pending_reg && lost_cnt_reg == 32'(LOST_CYC - 1);
   assign irq_event[2] = eval_pulse && sw_sync != switch_closed_flag;

   // Write one to clear; a new event in the same cycle wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_reg <= 3'b000;
         irq_mask_reg <= 3'b000;
      end
      else
      begin
         if (apb_wr && paddr == `APS_OFF_IRQ)
            irq_stat_reg <= (irq_stat_reg & ~pwdata[`APS_IRQ_W-1:0]) | irq_event;
         else
            irq_stat_reg <= irq_stat_reg | irq_event;
         if (apb_wr && paddr == `APS_OFF_MASK)
            irq_mask_reg <= pwdata[`APS_IRQ_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(irq_stat_reg & irq_mask_reg);
   end

   // Read data prepared in setup so it stands during the access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable)
         begin
            pslverr <= !(paddr == `APS_OFF_CTRL || paddr == `APS_OFF_STAT || paddr == `APS_OFF_POS
               || paddr == `APS_OFF_FRAME0 || paddr == `APS_OFF_FRAME1 || paddr == `APS_OFF_IRQ
               || paddr == `APS_OFF_MASK);
         end
         if (apb_rd)
         begin
            unique case (paddr)
               `APS_OFF_CTRL: prdata <= {25'h000_0000, programmed_address_bits_reg, 1'b0, hw_fixed_reg};
               `APS_OFF_STAT: prdata <= {27'h000_0000, secure_position_req, lost_pending_reg,
                  switch_closed_flag, pin_reg};
               `APS_OFF_POS: prdata <= {16'h0000, pos_latched_reg};
               `APS_OFF_FRAME0: prdata <= {pos_latched_reg[7:0], pos_latched_reg[15:8],
                  switch_closed_flag, node_address, 8'h00} >> 8;
               `APS_OFF_FRAME1: prdata <= {16'h0000, checksum, status_flags};
               `APS_OFF_IRQ: prdata <= {29'h0000_0000, irq_stat_reg};
               `APS_OFF_MASK: prdata <= {29'h0000_0000, irq_mask_reg};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// ### verif/aps_sense_chk.sv
// Port checker for the sensing block
`timescale 1ns/10ps
module aps_sense_chk
#(
   parameter int LOST_CYC = 2000,
   parameter int HALF_CYC = 200,
   parameter int PULSE_CYC = 20
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic high_side_probe,
   input wire logic low_side_probe,
   input wire logic [1:0] address_state,
   input wire logic secure_position_req,
   input wire logic switch_closed_flag
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic pr_q;
   logic last_low;
   int wid;
   int per;
   int since;
   int flt;
   wire probe = high_side_probe | low_side_probe;
   // Pulse width, spacing, side and lost-pin age; counters let width and spacing be checked exactly and lost-pin age within three cycles
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pr_q <= 1'b0;
         last_low <= 1'b0;
         wid <= 0;
         per <= 0;
         since <= 0;
         flt <= 0;
      end
      else
      begin
         pr_q <= probe;
         wid <= probe ? wid + 1 : 0;
         since <= probe ? 0 : since + 1;
         flt <= (address_state == aps_pkg::APS_FLOAT) ? flt + 1 : 0;
         if (probe && !pr_q)
         begin
            per <= 1;
            last_low <= low_side_probe;
         end
         else if (per != 0)
            per <= per + 1;
      end
   end
   AST_NOT_BOTH: assert property (!(high_side_probe && low_side_probe))
      else $error("both probes active");
   AST_WIDTH: assert property (!probe && pr_q |-> wid == PULSE_CYC)
      else $error("probe pulse width wrong");
   AST_PERIOD: assert property (probe && !pr_q && per != 0 |-> per == HALF_CYC && low_side_probe != last_low)
      else $error("probe spacing or alternation wrong");
   AST_CODE: assert property (address_state != 2'b11)
      else $error("illegal pin state code");
   AST_LOST: assert property ($rose(secure_position_req) |-> flt >= LOST_CYC - 3 && flt <= LOST_CYC + 3)
      else $error("secure request delay wrong");
   AST_CANCEL: assert property ((address_state != aps_pkg::APS_FLOAT) [*3] |-> !secure_position_req)
      else $error("secure request not cancelled");
   AST_SIDE: assert property ($changed(address_state) |-> since <= 8
      && (address_state != aps_pkg::APS_HIGH || last_low) && (address_state != aps_pkg::APS_LOW || !last_low))
      else $error("pin state change off its probe");
   AST_SW_SYNC: assert property ($changed(switch_closed_flag) |-> since <= 8)
      else $error("switch flag changed between pulses");
   AST_READY: assert property (psel && !penable |=> pready)
      else $error("no answer in access cycle");
   AST_READY_ONLY: assert property (pready |-> psel && penable)
      else $error("answer outside access cycle");
endmodule

// ### verif/aps_wiring.sv
// Resistor wiring model on the address and switch pins
`timescale 1ns/10ps
module aps_wiring
(
   input wire logic high_side_probe,
   input wire logic low_side_probe,
   input wire logic [1:0] wiring,
   input wire logic sw_closed,
   output logic sense_comparator_out,
   output logic switch_comparator_out
);
   // Current flows only through a closed probe switch, so no pulse means a low comparator
   assign sense_comparator_out = (low_side_probe & (wiring == 2'd1)) | (high_side_probe & (wiring == 2'd2));
   // A closed switch only shows while probed; between pulses the line toggles back low
   assign switch_comparator_out = sw_closed & (high_side_probe | low_side_probe);
endmodule

// ### verif/test_address_pin_switch_sensing.sv
// Testbench for the address pin and switch sensing block
`timescale 1ns/10ps
module test_address_pin_switch_sensing;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sense_comparator_out;
   logic switch_comparator_out;
   logic [15:0] actual_position = 16'h8123;
   logic [7:0] status_flags = 8'hA5;
   logic high_side_probe;
   logic low_side_probe;
   logic [1:0] address_state;
   logic secure_position_req;
   logic switch_closed_flag;
   logic irq;
   logic [1:0] wiring = 2'd0;
   logic sw_closed = 1'b0;
   logic [31:0] rd;
   logic err;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   always #5 pclk = ~pclk;
   aps_sense #(.LOST_CYC(2000), .HALF_CYC(200), .PULSE_CYC(20)) u_dut (.*);
   aps_wiring u_wire (.*);
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One APB transfer; the request is held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 20)
         n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Bounded run; a hang counts as a mismatch
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         n_errors++;
         finish_test();
      end
   end
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("reset state", 32'(address_state), 32'h0000_0000);
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      chk("slverr", 32'(err), 32'h0000_0001);
      chk("bad read", rd, 32'h0000_0000);
      wiring <= 2'd1;
      apb(1'b1, 12'h000, 32'h0000_0051);
      apb(1'b1, 12'h018, 32'h0000_0007);
      repeat (900) @(posedge pclk);
      chk("high", 32'(address_state), 32'(aps_pkg::APS_HIGH));
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk("stat high", rd, 32'h0000_0002);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk("frame0", rd, 32'h0023_8155);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk("frame1", rd, 32'h0000_60A5);
      // Inputs change mid-pulse; the latched pair must move only at pulse end
      @(posedge high_side_probe);
      @(posedge pclk);
      actual_position <= 16'h0BEE;
      sw_closed <= 1'b1;
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("pos held", rd, 32'h0000_8123);
      chk("sw held", 32'(switch_closed_flag), 32'h0000_0000);
      repeat (30) @(posedge pclk);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk("pos new", rd, 32'h0000_0BEE);
      chk("sw closed", 32'(switch_closed_flag), 32'h0000_0001);
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk("irq sw", rd, 32'h0000_0004);
      chk("irq line", 32'(irq), 32'h0000_0001);
      apb(1'b1, 12'h014, 32'h0000_0004);
      @(posedge pclk);
      chk("irq clr", 32'(irq), 32'h0000_0000);
      // Lost pin: float at once, request only after the debounce
      wiring <= 2'd0;
      repeat (440) @(posedge pclk);
      chk("float", 32'(address_state), 32'(aps_pkg::APS_FLOAT));
      chk("req early", 32'(secure_position_req), 32'h0000_0000);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk("stat lost", rd, 32'h0000_000C);
      repeat (2000) @(posedge pclk);
      chk("req", 32'(secure_position_req), 32'h0000_0001);
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk("irq lost", rd, 32'h0000_0003);
      apb(1'b1, 12'h018, 32'h0000_0000);
      @(posedge pclk);
      chk("irq masked", 32'(irq), 32'h0000_0000);
      apb(1'b1, 12'h014, 32'h0000_0003);
      // Ground wiring cancels the request, then losing it floats from low
      wiring <= 2'd2;
      repeat (440) @(posedge pclk);
      chk("low", 32'(address_state), 32'(aps_pkg::APS_LOW));
      chk("req cancel", 32'(secure_position_req), 32'h0000_0000);
      wiring <= 2'd0;
      sw_closed <= 1'b0;
      repeat (440) @(posedge pclk);
      chk("low float", 32'(address_state), 32'(aps_pkg::APS_FLOAT));
      chk("sw open", 32'(switch_closed_flag), 32'h0000_0000);
      finish_test();
   end
endmodule
bind aps_sense aps_sense_chk #(.LOST_CYC(LOST_CYC), .HALF_CYC(HALF_CYC), .PULSE_CYC(PULSE_CYC)) u_chk (.*);
